// [ascr_regs.sv]
// Status word and correction register bank of the sigma-delta converter.
// Assumes host port signals and filter datapath status are synchronous to sys_clk.
`timescale 1ns/10ps

module ascr_regs
	import ascr_pkg::*;
#(
	parameter logic [1:0] PART_CODE  = 2'h1,
	parameter logic [2:0] DIE_REV    = 3'h0,
	parameter int         RES_WIDTH  = ASCR_RESULT_WIDTH
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire ascr_write_type        host_write,
	input  wire logic                  host_rd,
	output logic       [15:0]          host_rdata,
	output logic                       host_rdata_valid,
	input  wire logic  [15:0]          conv_word,
	input  wire logic                  result_valid_flag,
	input  wire logic                  reduced_power_flag,
	input  wire logic                  stage3_bypassed,
	input  wire logic                  stage1_bypassed,
	input  wire logic  [2:0]           decimation_setting,
	input  wire logic                  user_filter_active,
	input  wire logic                  coeff_download_request,
	input  wire logic                  coeff_word_valid,
	input  wire logic  [15:0]          coeff_word,
	input  wire logic                  coeff_checksum_valid,
	input  wire logic  [15:0]          coeff_checksum_word,
	input  wire logic                  filter_pass_valid,
	input  wire logic  [15:0]          filter_pass_checksum,
	input  wire logic                  stage1_valid,
	input  wire logic  [15:0]          stage1_magnitude,
	input  wire logic                  mod_sample_valid,
	input  wire logic                  mod_fullscale,
	input  wire logic                  corr_in_valid,
	input  wire logic  [RES_WIDTH-1:0] corr_in,
	output logic       [RES_WIDTH-1:0] corr_out,
	output logic                       corr_out_valid,
	output ascr_status_type            status_word
);

	// ----------------------------------------------------------------
	// Host write sequencing
	// ----------------------------------------------------------------
	logic        addr_phase_reg;
	logic [15:0] addr_reg;
	logic [15:0] offset_correction_reg;
	logic [15:0] gain_correction_reg;
	logic [15:0] overrange_threshold_reg;
	logic [3:0]  read_select_reg;
	logic        data_wr;

	assign data_wr = host_write.wr && !addr_phase_reg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			addr_phase_reg <= 1'b1;
			addr_reg       <= 16'h0000;
		end else if (host_write.wr && !coeff_download_request) begin
			addr_phase_reg <= ~addr_phase_reg;
			if (addr_phase_reg) begin
				addr_reg <= host_write.data;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			offset_correction_reg   <= ASCR_OFFSET_RESET;
			gain_correction_reg     <= ASCR_GAIN_RESET;
			overrange_threshold_reg <= ASCR_OVERRANGE_RESET;
		end else if (data_wr && !coeff_download_request) begin
			case (addr_reg)
				ASCR_ADDR_OFFSET:    offset_correction_reg   <= host_write.data;
				ASCR_ADDR_GAIN:      gain_correction_reg     <= host_write.data;
				ASCR_ADDR_OVERRANGE: overrange_threshold_reg <= host_write.data;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read selection
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			read_select_reg <= 4'h0;
		end else if (data_wr && !coeff_download_request && addr_reg == ASCR_ADDR_CONTROL1) begin
			read_select_reg <= host_write.data[ASCR_SEL_OVERRANGE_BIT:ASCR_SEL_STATUS_BIT];
		end else if (host_rd) begin
			read_select_reg <= 4'h0;
		end
	end

	// Priority keeps the answer defined if the host sets several bits.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			host_rdata       <= 16'h0000;
			host_rdata_valid <= 1'b0;
		end else begin
			host_rdata_valid <= host_rd;
			if (host_rd) begin
				if (read_select_reg[3]) begin
					host_rdata <= overrange_threshold_reg;
				end else if (read_select_reg[2]) begin
					host_rdata <= gain_correction_reg;
				end else if (read_select_reg[1]) begin
					host_rdata <= offset_correction_reg;
				end else if (read_select_reg[0]) begin
					host_rdata <= status_word;
				end else begin
					host_rdata <= conv_word;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Coefficient download checksum
	// ----------------------------------------------------------------
	logic [15:0] dl_sum_reg;
	logic        download_checksum_match_reg;
	logic        filt_ok_reg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dl_sum_reg <= 16'h0000;
			download_checksum_match_reg  <= 1'b0;
		end else if (coeff_checksum_valid) begin
			download_checksum_match_reg  <= (dl_sum_reg == coeff_checksum_word);
			dl_sum_reg <= 16'h0000;
		end else if (coeff_word_valid) begin
			dl_sum_reg <= 16'(dl_sum_reg + coeff_word);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			filt_ok_reg <= 1'b0;
		end else if (!user_filter_active) begin
			filt_ok_reg <= 1'b0;
		end else if (filter_pass_valid) begin
			filt_ok_reg <= (filter_pass_checksum == coeff_checksum_word);
		end
	end

	// ----------------------------------------------------------------
	// Over-range detection
	// ----------------------------------------------------------------
	logic [2:0] fs_run_reg;
	logic       ovr_reg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fs_run_reg <= 3'h0;
		end else if (mod_sample_valid) begin
			if (!mod_fullscale) begin
				fs_run_reg <= 3'h0;
			end else if (fs_run_reg <= ASCR_FULLSCALE_RUN) begin
				fs_run_reg <= 3'(fs_run_reg + 3'h1);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ovr_reg <= 1'b0;
		end else if (mod_sample_valid && mod_fullscale && fs_run_reg >= ASCR_FULLSCALE_RUN) begin
			ovr_reg <= 1'b1;
		end else if (stage1_valid) begin
			ovr_reg <= (stage1_magnitude > overrange_threshold_reg);
		end
	end

	// ----------------------------------------------------------------
	// Status word
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			status_word <= '0;
		end else begin
			status_word.part_code_bits          <= PART_CODE;
			status_word.die_revision_index      <= DIE_REV;
			status_word.result_valid_flag       <= result_valid_flag;
			status_word.reduced_power_flag      <= reduced_power_flag;
			status_word.overrange_flag          <= ovr_reg;
			status_word.download_checksum_match <= download_checksum_match_reg;
			status_word.filter_checksum_match   <= filt_ok_reg;
			status_word.user_filter_active      <= user_filter_active;
			status_word.stage3_bypassed         <= stage3_bypassed;
			status_word.stage1_bypassed         <= stage1_bypassed;
			status_word.decimation_setting      <= decimation_setting;
		end
	end

	// ----------------------------------------------------------------
	// Gain then offset correction
	// ----------------------------------------------------------------
	function automatic logic signed [RES_WIDTH-1:0] ascr_sat(input logic signed [RES_WIDTH+1:0] v);
		logic signed [RES_WIDTH+1:0] hi;
		logic signed [RES_WIDTH+1:0] lo;
		hi = (RES_WIDTH+2)'({1'b0, {(RES_WIDTH-1){1'b1}}});
		lo = -hi - (RES_WIDTH+2)'(1);
		if (v > hi) begin
			return hi[RES_WIDTH-1:0];
		end else if (v < lo) begin
			return lo[RES_WIDTH-1:0];
		end
		return v[RES_WIDTH-1:0];
	endfunction

	logic signed [RES_WIDTH+16:0] prod_reg;
	logic                         prod_valid_reg;
	logic signed [RES_WIDTH+1:0]  gained;
	logic signed [RES_WIDTH+1:0]  offset_ext;

	// Unity gain is 0x8000, so the product is shifted down by fifteen.
	assign gained = (RES_WIDTH+2)'(prod_reg >>> 15);
	// Full offset code spans 1/128 of full scale, i.e. 0.78125 percent.
	assign offset_ext = (RES_WIDTH+2)'($signed(offset_correction_reg) <<< (RES_WIDTH-1-15-7));

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prod_reg       <= '0;
			prod_valid_reg <= 1'b0;
		end else begin
			prod_valid_reg <= corr_in_valid;
			if (corr_in_valid) begin
				prod_reg <= $signed(corr_in) * $signed({1'b0, gain_correction_reg});
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			corr_out       <= '0;
			corr_out_valid <= 1'b0;
		end else begin
			corr_out_valid <= prod_valid_reg;
			if (prod_valid_reg) begin
				corr_out <= ascr_sat(gained + offset_ext);
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_status_readonly: assert property (@(posedge sys_clk) disable iff (rst)
		host_write.wr |=> status_word == {PART_CODE, DIE_REV, $past(result_valid_flag),
		$past(reduced_power_flag), $past(ovr_reg), $past(download_checksum_match_reg), $past(filt_ok_reg),
		$past(user_filter_active), $past(stage3_bypassed), $past(stage1_bypassed),
		$past(decimation_setting)})
		else $error("status word disturbed by host write");

	a_select_returns: assert property (@(posedge sys_clk) disable iff (rst)
		host_rd && read_select_reg[2] && !read_select_reg[3] |=> host_rdata == $past(gain_correction_reg))
		else $error("gain selection not returned");

	a_select_clears: assert property (@(posedge sys_clk) disable iff (rst)
		host_rd && !(data_wr && addr_reg == ASCR_ADDR_CONTROL1) |=> read_select_reg == 4'h0)
		else $error("read selection not cleared");

	a_plain_read_conv: assert property (@(posedge sys_clk) disable iff (rst)
		host_rd && read_select_reg == 4'h0 |=> host_rdata == $past(conv_word) && host_rdata_valid)
		else $error("conversion word not returned");

	a_fullscale_ovr: assert property (@(posedge sys_clk) disable iff (rst)
		mod_sample_valid && mod_fullscale && fs_run_reg == 3'h4 |=> ovr_reg ##1 status_word.overrange_flag)
		else $error("full scale run not flagged");

	a_threshold_ovr: assert property (@(posedge sys_clk) disable iff (rst)
		stage1_valid && !mod_sample_valid && stage1_magnitude <= overrange_threshold_reg |=> !ovr_reg)
		else $error("over-range set below threshold");

	a_dl_match: assert property (@(posedge sys_clk) disable iff (rst)
		coeff_checksum_valid |=> download_checksum_match_reg == ($past(dl_sum_reg) == $past(coeff_checksum_word)))
		else $error("download checksum mismatch");

	a_status_mirror: assert property (@(posedge sys_clk) disable iff (rst)
		1'b1 |=> status_word.decimation_setting == $past(decimation_setting))
		else $error("decimation not mirrored");

	a_corr_latency: assert property (@(posedge sys_clk) disable iff (rst)
		corr_in_valid |-> ##2 corr_out_valid)
		else $error("correction latency wrong");

endmodule // ascr_regs

// [ascr_pkg.sv]
// Package for the converter status and correction register bank.
// Assumes a single 40 MHz clock domain and a 16-bit parallel host port.
package ascr_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] ASCR_ADDR_CONTROL1  = 16'h0001;
	localparam logic [15:0] ASCR_ADDR_OFFSET    = 16'h0003;
	localparam logic [15:0] ASCR_ADDR_GAIN      = 16'h0004;
	localparam logic [15:0] ASCR_ADDR_OVERRANGE = 16'h0005;

	// ----------------------------------------------------------------
	// Reset values and reference codes
	// ----------------------------------------------------------------
	localparam logic [15:0] ASCR_OFFSET_RESET     = 16'h0000;
	localparam logic [15:0] ASCR_GAIN_RESET       = 16'hA000;
	localparam logic [15:0] ASCR_OVERRANGE_RESET  = 16'hCCCC;
	localparam logic [15:0] ASCR_GAIN_UNITY       = 16'h8000;
	localparam logic [15:0] ASCR_OFFSET_MAX_POS   = 16'h7FFF;
	localparam logic [15:0] ASCR_OFFSET_MAX_NEG   = 16'h8000;

	// ----------------------------------------------------------------
	// Control word read-selection bits
	// ----------------------------------------------------------------
	localparam int ASCR_SEL_OVERRANGE_BIT = 14;
	localparam int ASCR_SEL_GAIN_BIT      = 13;
	localparam int ASCR_SEL_OFFSET_BIT    = 12;
	localparam int ASCR_SEL_STATUS_BIT    = 11;

	// ----------------------------------------------------------------
	// Timing and widths
	// ----------------------------------------------------------------
	localparam logic [2:0] ASCR_FULLSCALE_RUN = 3'h4;
	localparam int         ASCR_RESULT_WIDTH  = 24;

	// Status word layout, most significant field first.
	typedef struct packed {
		logic [1:0] part_code_bits;
		logic [2:0] die_revision_index;
		logic       result_valid_flag;
		logic       reduced_power_flag;
		logic       overrange_flag;
		logic       download_checksum_match;
		logic       filter_checksum_match;
		logic       user_filter_active;
		logic       stage3_bypassed;
		logic       stage1_bypassed;
		logic [2:0] decimation_setting;
	} ascr_status_type;

	// Host port write strobe group.
	typedef struct packed {
		logic        wr;
		logic [15:0] data;
	} ascr_write_type;

endpackage : ascr_pkg

// [ascr_host.sv]
// Host processor model on the 16-bit parallel register port.
// Assumes the bench calls its tasks from one process, synchronous to sys_clk.
`timescale 1ns/10ps

module ascr_host
	import ascr_pkg::*;
(
	input  wire logic        sys_clk,
	output ascr_write_type   host_write,
	output logic             host_rd,
	input  wire logic [15:0] host_rdata,
	input  wire logic        host_rdata_valid
);
	initial begin
		host_write = '0;
		host_rd    = 1'b0;
	end

	// Writes the address word, then one data word.
	task automatic write_reg(input logic [15:0] addr, input logic [15:0] data);
		@(posedge sys_clk);
		host_write <= '{wr: 1'b1, data: addr};
		@(posedge sys_clk);
		host_write <= '{wr: 1'b1, data: data};
		@(posedge sys_clk);
		host_write <= '{wr: 1'b0, data: ~data};
	endtask

	// Issues one read pulse and takes the answer one cycle later.
	task automatic read_word(output logic [15:0] val, output logic ok);
		@(posedge sys_clk);
		host_rd <= 1'b1;
		@(posedge sys_clk);
		host_rd <= 1'b0;
		#1;
		ok  = host_rdata_valid;
		val = host_rdata;
	endtask

	// Sets exactly one selection bit, then reads the selected register.
	task automatic read_sel(input int sel, output logic [15:0] val, output logic ok);
		write_reg(ASCR_ADDR_CONTROL1, 16'h0001 << sel);
		read_word(val, ok);
	endtask
endmodule // ascr_host

// [tb_adc_status_and_correction_regs.sv]
// Self-checking bench for the status and correction register bank.
// Assumes the host model drives the register port; the bench drives the rest.
`timescale 1ns/10ps

module tb_adc_status_and_correction_regs;
	import ascr_pkg::*;
	localparam logic [1:0] PART = 2'h2; // Arbitrary part code.
	localparam logic [2:0] DIE  = 3'h5; // Arbitrary die revision.
	logic sys_clk, rst, host_rd, host_rdata_valid, result_valid_flag, reduced_power_flag;
	logic stage3_bypassed, stage1_bypassed, user_filter_active, coeff_download_request;
	logic coeff_word_valid, coeff_checksum_valid, filter_pass_valid, stage1_valid;
	logic mod_sample_valid, mod_fullscale, corr_in_valid, corr_out_valid;
	logic [2:0] decimation_setting;
	logic [15:0] host_rdata, conv_word, coeff_word, coeff_checksum_word;
	logic [15:0] filter_pass_checksum, stage1_magnitude, r, r2, g, o, ref_m;
	logic [15:0] lfsr_reg = 16'h0048;
	logic [15:0] mdl [3];
	logic [23:0] corr_in, corr_out, x;
	logic ovr_m, dl_m, fo_m;
	ascr_write_type host_write;
	ascr_status_type status_word;
	int failures = 0;
	int num_checks = 0;

	ascr_regs #(.PART_CODE(PART), .DIE_REV(DIE)) i_ascr_regs (.sys_clk, .rst, .host_write,
		.host_rd, .host_rdata, .host_rdata_valid, .conv_word, .result_valid_flag,
		.reduced_power_flag, .stage3_bypassed, .stage1_bypassed, .decimation_setting,
		.user_filter_active, .coeff_download_request, .coeff_word_valid, .coeff_word,
		.coeff_checksum_valid, .coeff_checksum_word, .filter_pass_valid, .filter_pass_checksum,
		.stage1_valid, .stage1_magnitude, .mod_sample_valid, .mod_fullscale, .corr_in_valid,
		.corr_in, .corr_out, .corr_out_valid, .status_word);
	ascr_host i_ascr_host (.sys_clk, .host_write, .host_rd, .host_rdata, .host_rdata_valid);

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// Reference model and helpers
	// ----------------------------------------------------------------
	task automatic rnd(output logic [15:0] v);
		lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
		v = lfsr_reg;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	function automatic logic [15:0] st_exp();
		return {PART, DIE, result_valid_flag, reduced_power_flag, ovr_m, dl_m, fo_m,
			user_filter_active, stage3_bypassed, stage1_bypassed, decimation_setting};
	endfunction

	function automatic logic [23:0] corr_m(input logic [23:0] v);
		longint p;
		p = (longint'($signed(v)) * longint'(mdl[1])) >>> 15;
		p = p + longint'($signed(mdl[0])) * 2;
		if (p > 8388607) p = 8388607;
		if (p < -8388608) p = -8388608;
		return p[23:0];
	endfunction

	task automatic st_chk();
		repeat (2) @(posedge sys_clk);
		#1 check(status_word, st_exp());
	endtask

	task automatic lv();
		logic [15:0] v;
		rnd(v);
		@(posedge sys_clk);
		{result_valid_flag, reduced_power_flag, stage3_bypassed, stage1_bypassed} <= v[3:0];
		decimation_setting <= v[6:4];
		conv_word <= ~v;
	endtask

	task automatic rd_all();
		logic [15:0] v;
		logic ok;
		for (int s = 11; s < 15; s++) begin
			i_ascr_host.read_sel(s, v, ok);
			check(ok, 1'b1);
			check(v, (s == 11) ? st_exp() : mdl[s-12]);
			i_ascr_host.read_word(v, ok);
			check(v, conv_word);
		end
	endtask

	task automatic st1(input logic [15:0] m);
		@(posedge sys_clk);
		stage1_valid <= 1'b1;
		stage1_magnitude <= m;
		@(posedge sys_clk);
		stage1_valid <= 1'b0;
		ovr_m = m > mdl[2];
		st_chk();
	endtask

	task automatic ovr_run(input int n);
		for (int i = 0; i < 5; i++) begin
			@(posedge sys_clk);
			mod_sample_valid <= 1'b1;
			mod_fullscale <= (i < n);
		end
		@(posedge sys_clk);
		mod_sample_valid <= 1'b0;
		ovr_m = (n > 4);
		st_chk();
	endtask

	task automatic dload(input logic good);
		logic [15:0] s, v;
		s = 16'h0000;
		@(posedge sys_clk);
		coeff_download_request <= 1'b1;
		i_ascr_host.write_reg(ASCR_ADDR_GAIN, 16'h1234);
		for (int i = 0; i < 3; i++) begin
			rnd(v);
			s = s + v;
			@(posedge sys_clk);
			coeff_word_valid <= 1'b1;
			coeff_word <= v;
		end
		ref_m = good ? s : ~s;
		@(posedge sys_clk);
		coeff_word_valid <= 1'b0;
		coeff_checksum_valid <= 1'b1;
		coeff_checksum_word <= ref_m;
		@(posedge sys_clk);
		coeff_checksum_valid <= 1'b0;
		coeff_download_request <= 1'b0;
		dl_m = good;
		st_chk();
	endtask

	task automatic fpass(input logic [15:0] c);
		@(posedge sys_clk);
		filter_pass_valid <= 1'b1;
		filter_pass_checksum <= c;
		@(posedge sys_clk);
		filter_pass_valid <= 1'b0;
		fo_m = (c == ref_m);
		st_chk();
	endtask

	task automatic corr(input logic [23:0] v);
		@(posedge sys_clk);
		corr_in_valid <= 1'b1;
		corr_in <= v;
		@(posedge sys_clk);
		corr_in_valid <= 1'b0;
		for (int i = 0; i < 6 && corr_out_valid !== 1'b1; i++) @(posedge sys_clk) #1;
		if (corr_out_valid !== 1'b1) begin
			failures++;
			end_sim();
		end else begin
			check(corr_out, corr_m(v));
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		{result_valid_flag, reduced_power_flag, stage3_bypassed, stage1_bypassed} = '0;
		{user_filter_active, coeff_download_request, coeff_word_valid, coeff_checksum_valid} = '0;
		{filter_pass_valid, stage1_valid, mod_sample_valid, mod_fullscale, corr_in_valid} = '0;
		{decimation_setting, conv_word, coeff_word, coeff_checksum_word} = '0;
		{filter_pass_checksum, stage1_magnitude, corr_in} = '0;
		{ovr_m, dl_m, fo_m} = '0;
		mdl = '{ASCR_OFFSET_RESET, ASCR_GAIN_RESET, ASCR_OVERRANGE_RESET};
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		lv();
		st_chk();
		rd_all();
		st1(16'hCCCC);
		st1(16'hCCCD);
		st1(16'h0000);
		ovr_run(4);
		ovr_run(5);
		st1(16'h0000);
		dload(1'b0);
		dload(1'b1);
		rd_all();
		@(posedge sys_clk);
		user_filter_active <= 1'b1;
		fpass(ref_m);
		fpass(~ref_m);
		fpass(ref_m);
		@(posedge sys_clk);
		user_filter_active <= 1'b0;
		fo_m = 1'b0;
		st_chk();
		for (int k = 0; k < 2; k++) begin
			for (int a = 3; a < 7; a++) begin
				rnd(r);
				i_ascr_host.write_reg(16'(a), r);
				if (a < 6) mdl[a-3] = r;
			end
			lv();
			st_chk();
			rd_all();
		end
		for (int k = 0; k < 4; k++) begin
			rnd(r);
			rnd(r2);
			g = (k == 0) ? 16'h8000 : (k == 1) ? r : 16'hFFFF;
			o = (k == 0) ? 16'h0000 : (k == 1) ? r2 : (k == 2) ? 16'h7FFF : 16'h8000;
			x = (k == 2) ? 24'h7FFFFF : (k == 3) ? 24'h800000 : {r, r2[7:0]};
			i_ascr_host.write_reg(ASCR_ADDR_GAIN, g);
			i_ascr_host.write_reg(ASCR_ADDR_OFFSET, o);
			mdl[1] = g;
			mdl[0] = o;
			corr(x);
		end
		rd_all();
		end_sim();
	end
endmodule // tb_adc_status_and_correction_regs
